/* cirs_core_model.sv */
// Purpose: processor side of the expansion bus
// Assumes: reads answer one cycle after the taken edge
// Notes: idle address and data are inverted so stale values never look valid
`timescale 1ns/10ps
// ************************************************
// core bus model
// ************************************************
module cirs_core_model (
  input wire clock_i,
  input wire [15:0] rd_data_i,
  output reg [15:0] addr_o,
  output reg rd_o,
  output reg wr_o,
  output reg [15:0] wr_data_o,
  output reg [2:0] thread_o
);
  // quiet bus until the first call
  initial begin
    addr_o = 16'h0000;
    rd_o = 1'b0;
    wr_o = 1'b0;
    wr_data_o = 16'h0000;
    thread_o = 3'h0;
  end
  // one write; never raised together with a read
  task wr(input [15:0] a, input [15:0] d);
    begin
      @(posedge clock_i);
      addr_o <= a;
      wr_data_o <= d;
      wr_o <= 1'b1;
      @(posedge clock_i);
      wr_o <= 1'b0;
      addr_o <= ~a;
      wr_data_o <= ~d;
    end
  endtask
  // one read by thread t, data taken once settled
  task rd(input [15:0] a, input [2:0] t, output [15:0] d);
    begin
      @(posedge clock_i);
      addr_o <= a;
      thread_o <= t;
      rd_o <= 1'b1;
      @(posedge clock_i);
      rd_o <= 1'b0;
      addr_o <= ~a;
      @(negedge clock_i);
      d = rd_data_i;
    end
  endtask
endmodule

/* cirs_map.vh */
// Purpose: constants for the core internal register set
// Assumes: 16-bit processor expansion bus, register set at top of memory
// Notes: offsets are word offsets from the register set base
`ifndef CIRS_MAP_VH
`define CIRS_MAP_VH
// ************************************************
// placement
// ************************************************
`define CIRS_BASE_HI 12'hFFF
`define CIRS_OFS_W 4
// ************************************************
// register offsets
// ************************************************
`define CIRS_VER_OFS 4'h0
`define CIRS_TID_OFS 4'h1
`define CIRS_CLR_OFS 4'h2
`define CIRS_IEN_OFS 4'h3
`define CIRS_OPE_OFS 4'h4
`define CIRS_STK_OFS 4'h5
`define CIRS_PLO_OFS 4'h8
`define CIRS_PHI_OFS 4'h9
// ************************************************
// live bit masks and reset values
// ************************************************
`define CIRS_LIVE_ALL 16'hFFFF
`define CIRS_LIVE_BYTE 16'h00FF
`define CIRS_LIVE_TID 16'h0007
`define CIRS_RST_ZERO 16'h0000
// ************************************************
// output modes
// ************************************************
`define CIRS_OUT_ZERO 2'h0
`define CIRS_OUT_PASSTHROUGH 2'h1
`define CIRS_OUT_WRITE_HELD 2'h2
`define CIRS_OUT_READ 2'h3
// ************************************************
// read modes
// ************************************************
`define CIRS_RD_PASSTHROUGH 3'h0
`define CIRS_RD_STICKY_CLEAR_BY_READ 3'h1
`define CIRS_RD_STICKY_CLEAR_BY_WRITE 3'h2
`define CIRS_RD_ENABLED_FLOP_CAPTURE 3'h3
`define CIRS_RD_OUT 3'h4
`endif

/* cirs_reg_set.v */
// Purpose: internal register set of a multi-threaded core, built from base registers
// Assumes: one clock, synchronous active-low reset, read data one cycle after strobe
// Notes: unused offsets read zero and ignore writes
`timescale 1ns/10ps
`include "cirs_map.vh"

// ************************************************
// base register
// ************************************************
module cirs_base_reg #(
  parameter [3:0] OFS = 4'h0,
  parameter [1:0] OUT_MODE = `CIRS_OUT_ZERO,
  parameter [2:0] RD_MODE = `CIRS_RD_PASSTHROUGH,
  parameter [15:0] LIVE = `CIRS_LIVE_ALL,
  parameter [15:0] RST_VAL = `CIRS_RST_ZERO,
  parameter IN_SYNC = 0,
  parameter IN_EDGE = 0
) (
  input wire clock_i,
  input wire reset_n_i,
  input wire [3:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [15:0] wr_data_i,
  input wire cap_en_i,
  input wire [15:0] reg_in_i,
  output wire [15:0] rd_data_o,
  output wire [15:0] reg_out_o
);
  reg [15:0] sync1_ff;
  reg [15:0] sync2_ff;
  reg [15:0] prev_ff;
  reg [15:0] rd_q_ff;
  reg [15:0] out_q_ff;
  reg [15:0] nxt_rd_q;
  reg [15:0] rd_core;
  reg [15:0] rd_val;
  reg [15:0] out_v;
  wire hit;
  wire rd_hit;
  wire wr_hit;
  wire [15:0] in_v;
  wire [15:0] in_e;

  // offset match; the shim has already qualified the strobes
  assign hit = (addr_i == OFS);
  assign rd_hit = rd_i & hit;
  assign wr_hit = wr_i & hit;

  // optional two-stage resync, first stage feeds only the second
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      sync1_ff <= `CIRS_RST_ZERO;
      sync2_ff <= `CIRS_RST_ZERO;
      prev_ff <= `CIRS_RST_ZERO;
    end else begin
      sync1_ff <= reg_in_i;
      sync2_ff <= sync1_ff;
      prev_ff <= in_v;
    end
  end
  assign in_v = IN_SYNC ? sync2_ff : reg_in_i;
  // edge mode turns a level into a one-cycle rising event
  assign in_e = IN_EDGE ? (in_v & ~prev_ff) : in_v;

  // read side storage, one mode for the whole register
  always @* begin
    nxt_rd_q = rd_q_ff;
    case (RD_MODE)
      `CIRS_RD_STICKY_CLEAR_BY_READ: begin
        // set wins over the clearing read
        nxt_rd_q = (rd_q_ff & ~{16{rd_hit}}) | in_e;
      end
      `CIRS_RD_STICKY_CLEAR_BY_WRITE: begin
        // set wins over a write of one in the same cycle
        nxt_rd_q = (rd_q_ff & ~(wr_hit ? wr_data_i : 16'h0000)) | in_e;
      end
      `CIRS_RD_ENABLED_FLOP_CAPTURE: begin
        if (cap_en_i) begin
          nxt_rd_q = in_e;
        end
      end
      default: nxt_rd_q = rd_q_ff;
    endcase
  end

  // dead bits stay at zero so synthesis strips them
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      rd_q_ff <= RST_VAL & LIVE;
    end else begin
      rd_q_ff <= nxt_rd_q & LIVE;
    end
  end

  // write-held output latch, independent of the read path
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      out_q_ff <= RST_VAL & LIVE;
    end else if (wr_hit) begin
      out_q_ff <= wr_data_i & LIVE;
    end
  end

  // read value before the own-output choice, keeps the muxes loop free
  always @* begin
    case (RD_MODE)
      `CIRS_RD_PASSTHROUGH: rd_core = in_e;
      `CIRS_RD_OUT: rd_core = out_q_ff;
      default: rd_core = rd_q_ff;
    endcase
  end

  // output mux
  always @* begin
    case (OUT_MODE)
      `CIRS_OUT_PASSTHROUGH: out_v = in_e;
      `CIRS_OUT_WRITE_HELD: out_v = out_q_ff;
      `CIRS_OUT_READ: out_v = rd_core;
      default: out_v = 16'h0000;
    endcase
  end

  // own-output read mode returns whatever the output side drives
  always @* begin
    if (RD_MODE == `CIRS_RD_OUT) begin
      rd_val = out_v;
    end else begin
      rd_val = rd_core;
    end
  end

  // silent when not addressed so the set-level OR stays clean
  assign rd_data_o = rd_hit ? (rd_val & LIVE) : 16'h0000;
  assign reg_out_o = out_v & LIVE;
endmodule

// ************************************************
// register set top
// ************************************************
module cirs_reg_set #(
  parameter [7:0] VER_MAJOR = 8'h01,
  parameter [7:0] VER_MINOR = 8'h00
) (
  input wire clock_i,
  input wire reset_n_i,
  input wire [15:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [15:0] wr_data_i,
  input wire [2:0] thread_number_field_i,
  input wire [7:0] bad_opcode_bits_i,
  input wire [7:0] underflow_bits_i,
  input wire [7:0] overflow_bits_i,
  input wire [15:0] port_low_bits_i,
  input wire [15:0] port_high_bits_i,
  output reg [15:0] rd_data_o,
  output reg [7:0] thread_clear_o,
  output wire [7:0] irq_enable_o,
  output wire [15:0] port_low_bits_o,
  output wire [15:0] port_high_bits_o
);
  wire sel;
  wire rd_s;
  wire wr_s;
  wire [3:0] ofs;
  wire [15:0] rd_ver;
  wire [15:0] rd_tid;
  wire [15:0] rd_clr;
  wire [15:0] rd_ien;
  wire [15:0] rd_ope;
  wire [15:0] rd_stk;
  wire [15:0] rd_plo;
  wire [15:0] rd_phi;
  wire [15:0] clr_q;
  wire [15:0] ien_q;
  reg [7:0] clr_prev_ff;

  // ************************************************
  // shim
  // ************************************************
  // only the top sixteen words belong to the set
  assign sel = (addr_i[15:4] == `CIRS_BASE_HI);
  assign rd_s = rd_i & sel;
  assign wr_s = wr_i & sel & ~rd_i;
  assign ofs = addr_i[3:0];

  // ************************************************
  // base registers
  // ************************************************
  // version digits are meant to be decimal; raise the major on decode changes
  cirs_base_reg #(
    .OFS(`CIRS_VER_OFS),
    .OUT_MODE(`CIRS_OUT_ZERO),
    .RD_MODE(`CIRS_RD_PASSTHROUGH),
    .LIVE(`CIRS_LIVE_ALL)
  ) u_ver (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .addr_i(ofs),
    .rd_i(rd_s),
    .wr_i(wr_s),
    .wr_data_i(wr_data_i),
    .cap_en_i(1'b0),
    .reg_in_i({VER_MAJOR, VER_MINOR}),
    .rd_data_o(rd_ver),
    .reg_out_o()
  );

  // reader identity comes from the core pipeline on the same clock
  cirs_base_reg #(
    .OFS(`CIRS_TID_OFS),
    .OUT_MODE(`CIRS_OUT_ZERO),
    .RD_MODE(`CIRS_RD_PASSTHROUGH),
    .LIVE(`CIRS_LIVE_TID)
  ) u_tid (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .addr_i(ofs),
    .rd_i(rd_s),
    .wr_i(wr_s),
    .wr_data_i(wr_data_i),
    .cap_en_i(1'b0),
    .reg_in_i({13'h0000, thread_number_field_i}),
    .rd_data_o(rd_tid),
    .reg_out_o()
  );

  // clear bits read back what was written
  cirs_base_reg #(
    .OFS(`CIRS_CLR_OFS),
    .OUT_MODE(`CIRS_OUT_WRITE_HELD),
    .RD_MODE(`CIRS_RD_OUT),
    .LIVE(`CIRS_LIVE_BYTE),
    .RST_VAL(`CIRS_RST_ZERO)
  ) u_clr (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .addr_i(ofs),
    .rd_i(rd_s),
    .wr_i(wr_s),
    .wr_data_i(wr_data_i),
    .cap_en_i(1'b0),
    .reg_in_i(16'h0000),
    .rd_data_o(rd_clr),
    .reg_out_o(clr_q)
  );

  cirs_base_reg #(
    .OFS(`CIRS_IEN_OFS),
    .OUT_MODE(`CIRS_OUT_WRITE_HELD),
    .RD_MODE(`CIRS_RD_OUT),
    .LIVE(`CIRS_LIVE_BYTE),
    .RST_VAL(`CIRS_RST_ZERO)
  ) u_ien (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .addr_i(ofs),
    .rd_i(rd_s),
    .wr_i(wr_s),
    .wr_data_i(wr_data_i),
    .cap_en_i(1'b0),
    .reg_in_i(16'h0000),
    .rd_data_o(rd_ien),
    .reg_out_o(ien_q)
  );

  // error bits stay up until software writes a one
  cirs_base_reg #(
    .OFS(`CIRS_OPE_OFS),
    .OUT_MODE(`CIRS_OUT_ZERO),
    .RD_MODE(`CIRS_RD_STICKY_CLEAR_BY_WRITE),
    .LIVE(`CIRS_LIVE_BYTE)
  ) u_ope (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .addr_i(ofs),
    .rd_i(rd_s),
    .wr_i(wr_s),
    .wr_data_i(wr_data_i),
    .cap_en_i(1'b0),
    .reg_in_i({8'h00, bad_opcode_bits_i}),
    .rd_data_o(rd_ope),
    .reg_out_o()
  );

  cirs_base_reg #(
    .OFS(`CIRS_STK_OFS),
    .OUT_MODE(`CIRS_OUT_ZERO),
    .RD_MODE(`CIRS_RD_STICKY_CLEAR_BY_WRITE),
    .LIVE(`CIRS_LIVE_ALL)
  ) u_stk (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .addr_i(ofs),
    .rd_i(rd_s),
    .wr_i(wr_s),
    .wr_data_i(wr_data_i),
    .cap_en_i(1'b0),
    .reg_in_i({overflow_bits_i, underflow_bits_i}),
    .rd_data_o(rd_stk),
    .reg_out_o()
  );

  // port pins are foreign to the clock, so both halves resync
  cirs_base_reg #(
    .OFS(`CIRS_PLO_OFS),
    .OUT_MODE(`CIRS_OUT_WRITE_HELD),
    .RD_MODE(`CIRS_RD_PASSTHROUGH),
    .LIVE(`CIRS_LIVE_ALL),
    .IN_SYNC(1)
  ) u_plo (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .addr_i(ofs),
    .rd_i(rd_s),
    .wr_i(wr_s),
    .wr_data_i(wr_data_i),
    .cap_en_i(1'b0),
    .reg_in_i(port_low_bits_i),
    .rd_data_o(rd_plo),
    .reg_out_o(port_low_bits_o)
  );

  // high half is captured on the low-half read, same synchroniser depth
  // as the low half so both words come from one sampling edge
  cirs_base_reg #(
    .OFS(`CIRS_PHI_OFS),
    .OUT_MODE(`CIRS_OUT_WRITE_HELD),
    .RD_MODE(`CIRS_RD_ENABLED_FLOP_CAPTURE),
    .LIVE(`CIRS_LIVE_ALL),
    .IN_SYNC(1)
  ) u_phi (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .addr_i(ofs),
    .rd_i(rd_s),
    .wr_i(wr_s),
    .wr_data_i(wr_data_i),
    .cap_en_i(rd_s & (ofs == `CIRS_PLO_OFS)),
    .reg_in_i(port_high_bits_i),
    .rd_data_o(rd_phi),
    .reg_out_o(port_high_bits_o)
  );

  // ************************************************
  // read bus and thread controls
  // ************************************************
  // registered OR of all slices; unused offsets contribute nothing
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      rd_data_o <= 16'h0000;
    end else begin
      rd_data_o <= rd_ver | rd_tid | rd_clr | rd_ien | rd_ope | rd_stk | rd_plo | rd_phi;
    end
  end

  // a rising clear bit gives its thread a one-cycle clear; falling does nothing
  always @(posedge clock_i) begin
    if (!reset_n_i) begin
      clr_prev_ff <= 8'h00;
      thread_clear_o <= 8'h00;
    end else begin
      clr_prev_ff <= clr_q[7:0];
      thread_clear_o <= clr_q[7:0] & ~clr_prev_ff;
    end
  end

  assign irq_enable_o = ien_q[7:0];
endmodule

/* cirs_reg_set_props.sv */
// Purpose: port checks for the register set
// Assumes: default version 01.00, read data one cycle after the strobe
// Notes: bound to the register set top
`timescale 1ns/10ps
// ************************************************
// checker
// ************************************************
module cirs_reg_set_props (
  input wire clock_i,
  input wire reset_n_i,
  input wire [15:0] addr_i,
  input wire rd_i,
  input wire wr_i,
  input wire [15:0] wr_data_i,
  input wire [2:0] thread_number_field_i,
  input wire [7:0] bad_opcode_bits_i,
  input wire [15:0] rd_data_o,
  input wire [7:0] thread_clear_o,
  input wire [7:0] irq_enable_o,
  input wire [15:0] port_low_bits_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!reset_n_i);
  // flag raised, then a quiet cycle, so no clear can race the read
  sequence s_flag_seen;
    bad_opcode_bits_i[1] ##1 !wr_i;
  endsequence
  sequence s_flag_read;
    rd_i && addr_i == 16'hFFF4;
  endsequence
  a_ver_read: assert property (rd_i && addr_i == 16'hFFF0
    |=> rd_data_o == 16'h0100) else $error("version read wrong");
  a_tid_read: assert property (rd_i && addr_i == 16'hFFF1
    |=> rd_data_o == {13'h0000, $past(thread_number_field_i)}) else $error("thread id wrong");
  a_idle_zero: assert property (!rd_i |=> rd_data_o == 16'h0000)
    else $error("read data not idle");
  a_unused_zero: assert property (rd_i && (addr_i[15:4] != 12'hFFF
    || addr_i[3:1] == 3'h3 || addr_i[3:0] > 4'h9) |=> rd_data_o == 16'h0000)
    else $error("unused place read nonzero");
  a_clear_cause: assert property (thread_clear_o[0]
    |-> $past(wr_i && !rd_i && addr_i == 16'hFFF2 && wr_data_i[0], 2))
    else $error("clear pulse");
  a_irq_write: assert property (wr_i && !rd_i && addr_i == 16'hFFF3
    |=> irq_enable_o == $past(wr_data_i[7:0])) else $error("irq enable not written");
  a_port_write: assert property (wr_i && !rd_i && addr_i == 16'hFFF8
    |=> port_low_bits_o == $past(wr_data_i)) else $error("port low not written");
  a_flag_sticky: assert property (s_flag_seen ##1 s_flag_read |=> rd_data_o[1])
    else $error("opcode flag lost");
  a_reset_clears: assert property (disable iff (1'b0) !reset_n_i
    |=> irq_enable_o == 8'h00 && thread_clear_o == 8'h00) else $error("reset left bits");
endmodule

bind cirs_reg_set cirs_reg_set_props i_props (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .addr_i(addr_i), .rd_i(rd_i), .wr_i(wr_i), .wr_data_i(wr_data_i),
  .thread_number_field_i(thread_number_field_i), .bad_opcode_bits_i(bad_opcode_bits_i),
  .rd_data_o(rd_data_o), .thread_clear_o(thread_clear_o), .irq_enable_o(irq_enable_o),
  .port_low_bits_o(port_low_bits_o));

/* test_cirs_reg_set.sv */
// Purpose: self-checking bench for the register set
// Assumes: default version 01.00, 50 MHz clock
// Notes: all inputs are exercised, none tied
`timescale 1ns/10ps
// ************************************************
// bench
// ************************************************
module test_cirs_reg_set;
  reg clock_i;
  reg reset_n_i = 1'b0;
  reg [7:0] bad_opcode_bits_i = 8'h00;
  reg [7:0] underflow_bits_i = 8'h00;
  reg [7:0] overflow_bits_i = 8'h00;
  reg [15:0] port_low_bits_i = 16'h0000;
  reg [15:0] port_high_bits_i = 16'h0000;
  wire [15:0] addr_i;
  wire rd_i;
  wire wr_i;
  wire [15:0] wr_data_i;
  wire [2:0] thread_number_field_i;
  wire [15:0] rd_data_o;
  wire [7:0] thread_clear_o;
  wire [7:0] irq_enable_o;
  wire [15:0] port_low_bits_o;
  wire [15:0] port_high_bits_o;
  integer bad_count = 0;
  integer total_checks = 0;
  integer i;
  reg [15:0] got;
  cirs_reg_set i_cirs_reg_set (.clock_i(clock_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
    .rd_i(rd_i), .wr_i(wr_i), .wr_data_i(wr_data_i),
    .thread_number_field_i(thread_number_field_i), .bad_opcode_bits_i(bad_opcode_bits_i),
    .underflow_bits_i(underflow_bits_i), .overflow_bits_i(overflow_bits_i),
    .port_low_bits_i(port_low_bits_i), .port_high_bits_i(port_high_bits_i),
    .rd_data_o(rd_data_o), .thread_clear_o(thread_clear_o), .irq_enable_o(irq_enable_o),
    .port_low_bits_o(port_low_bits_o), .port_high_bits_o(port_high_bits_o));
  cirs_core_model core (.clock_i(clock_i), .rd_data_i(rd_data_o), .addr_o(addr_i),
    .rd_o(rd_i), .wr_o(wr_i), .wr_data_o(wr_data_i), .thread_o(thread_number_field_i));
  // 20 ns period
  initial begin
    clock_i = 1'b0;
    forever #10 clock_i = ~clock_i;
  end
  task chk(input [15:0] seen, input [15:0] exp);
    begin
      total_checks = total_checks + 1;
      if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task rc(input [15:0] a, input [15:0] e);
    begin
      core.rd(a, 3'h0, got);
      chk(got, e);
    end
  endtask
  task t_reset_and_ids;
    begin
      rc(16'hFFF3, 16'h0000);
      rc(16'hFFF2, 16'h0000);
      rc(16'hFFF0, 16'h0100);
      for (i = 0; i < 8; i = i + 1) begin
        core.rd(16'hFFF1, i[2:0], got);
        chk(got, {13'h0000, i[2:0]});
      end
      // unused places swallow writes
      for (i = 6; i < 16; i = i + 1) begin
        // offsets 8 and 9 are the port, not unused
        if (i < 8 || i > 9) begin
          core.wr(16'hFFF0 + i[15:0], 16'hFFFF);
          rc(16'hFFF0 + i[15:0], 16'h0000);
        end
      end
      core.wr(16'hFFE3, 16'h00FF);
      rc(16'hFFE3, 16'h0000);
      chk({8'h00, irq_enable_o}, 16'h0000);
    end
  endtask
  task t_controls;
    begin
      core.wr(16'hFFF3, 16'hFFA5);
      @(negedge clock_i);
      chk({8'h00, irq_enable_o}, 16'h00A5);
      rc(16'hFFF3, 16'h00A5);
      core.wr(16'hFFF2, 16'h0081);
      // the pulse follows the register update by one cycle
      repeat (2) @(negedge clock_i);
      chk({8'h00, thread_clear_o}, 16'h0081);
      @(negedge clock_i);
      chk({8'h00, thread_clear_o}, 16'h0000);
      // bit 0 stays high, bit 7 falls: neither may pulse
      core.wr(16'hFFF2, 16'h0001);
      repeat (2) @(negedge clock_i);
      chk({8'h00, thread_clear_o}, 16'h0000);
      rc(16'hFFF2, 16'h0001);
      core.wr(16'hFFF0, 16'h9999);
      rc(16'hFFF0, 16'h0100);
    end
  endtask
  task t_flags;
    begin
      @(posedge clock_i);
      bad_opcode_bits_i <= 8'h12;
      underflow_bits_i <= 8'h03;
      overflow_bits_i <= 8'h80;
      @(posedge clock_i);
      bad_opcode_bits_i <= 8'h00;
      underflow_bits_i <= 8'h00;
      overflow_bits_i <= 8'h00;
      rc(16'hFFF4, 16'h0012);
      rc(16'hFFF4, 16'h0012);
      core.wr(16'hFFF4, 16'h0002);
      rc(16'hFFF4, 16'h0010);
      // error still present while software clears: the set must win
      @(posedge clock_i);
      bad_opcode_bits_i <= 8'h10;
      core.wr(16'hFFF4, 16'h0010);
      bad_opcode_bits_i <= 8'h00;
      rc(16'hFFF4, 16'h0010);
      core.wr(16'hFFF4, 16'h0010);
      rc(16'hFFF4, 16'h0000);
      rc(16'hFFF5, 16'h8003);
      core.wr(16'hFFF5, 16'h8001);
      rc(16'hFFF5, 16'h0002);
    end
  endtask
  task t_port;
    begin
      core.wr(16'hFFF8, 16'h1234);
      core.wr(16'hFFF9, 16'hABCD);
      @(negedge clock_i);
      chk(port_low_bits_o, 16'h1234);
      chk(port_high_bits_o, 16'hABCD);
      @(posedge clock_i);
      port_low_bits_i <= 16'h5555;
      port_high_bits_i <= 16'hAAAA;
      repeat (3) @(posedge clock_i);
      rc(16'hFFF8, 16'h5555);
      @(posedge clock_i);
      port_high_bits_i <= 16'h0F0F;
      repeat (3) @(posedge clock_i);
      rc(16'hFFF9, 16'hAAAA);
      rc(16'hFFF8, 16'h5555);
      rc(16'hFFF9, 16'h0F0F);
    end
  endtask
  // reset in mid-run must wipe values that software has set
  task t_mid_reset;
    begin
      core.wr(16'hFFF3, 16'h00FF);
      core.wr(16'hFFF2, 16'h00F0);
      @(posedge clock_i);
      reset_n_i <= 1'b0;
      repeat (3) @(posedge clock_i);
      reset_n_i <= 1'b1;
      @(negedge clock_i);
      chk({8'h00, irq_enable_o}, 16'h0000);
      chk({8'h00, thread_clear_o}, 16'h0000);
      chk(port_low_bits_o, 16'h0000);
      chk(port_high_bits_o, 16'h0000);
      rc(16'hFFF2, 16'h0000);
      rc(16'hFFF3, 16'h0000);
      rc(16'hFFF5, 16'h0000);
    end
  endtask
  task give_verdict;
    begin
      if (bad_count == 0 && total_checks > 0) begin
        $display("ALL TESTS PASSED");
      end else begin
        $display("TESTS FAILED");
      end
      $finish;
    end
  endtask
  // a hang ends as a failure
  initial begin
    repeat (20000) @(posedge clock_i);
    bad_count = bad_count + 1;
    give_verdict;
  end
  initial begin
    repeat (20) @(posedge clock_i);
    reset_n_i <= 1'b1;
    t_reset_and_ids;
    t_controls;
    t_flags;
    t_port;
    t_mid_reset;
    give_verdict;
  end
endmodule
